// ==== src/psmc_top.sv ====
`timescale 1ns/10ps
// Function
// - All segments lit one second after power-up
// - Switch output inactive for one cycle at start inside hysteresis band
// - Five second menu hold heads for programming
// - Nonzero access code forces a code prompt
// - Sixty idle seconds abandon edit, keep value
// - Button_a plus menu chord returns to display
// - Zero offset adjust cancels displayed offset
// - Offset limited to three percent, default no
module psmc_top #(
   parameter longint unsigned LAMP_CYC = psmc_pkg::LAMP_TEST_CYC,
   parameter longint unsigned HOLD_CYC = psmc_pkg::MENU_HOLD_CYC,
   parameter longint unsigned IDLE_CYC = psmc_pkg::EDIT_TIMEOUT_CYC,
   parameter logic [20:0] DEB_CYC = 21'(psmc_pkg::DEBOUNCE_CYC),
   parameter int unsigned RANGE_W = 16
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic btn_menu,
   input wire logic button_a,
   input wire logic btn_confirm,
   input wire logic [psmc_pkg::CODE_W-1:0] access_code,
   input wire logic code_entry_done,
   input wire logic [psmc_pkg::CODE_W-1:0] code_entered,
   input wire logic edit_select,
   input wire logic zero_select,
   input wire logic in_hyst_band,
   input wire logic sw_request,
   input wire logic [RANGE_W-1:0] offset_raw,
   input wire logic [RANGE_W-1:0] range_span,
   output logic lamp_test,
   output logic outputs_enable,
   output logic switch_out,
   output logic prog_mode,
   output logic code_prompt,
   output logic edit_active,
   output logic edit_commit,
   output logic edit_abandon,
   output logic zero_offset_adjust,
   output logic offset_valid,
   output logic [RANGE_W-1:0] zero_offset
);
   import psmc_pkg::*;
   psmc_state_t state_r, state_nxt;
   logic [37:0] tmr_r, tmr_nxt;
   logic menu_c, a_c, conf_c;
   logic outen_r, outen_nxt, sw_r, sw_nxt, zadj_r, zadj_nxt, commit_r, commit_nxt, aban_r, aban_nxt;
   logic chord, any_btn;
   logic [RANGE_W-1:0] ofs_r, ofs_nxt;
   logic [RANGE_W+6:0] limit;
   initial begin
      if (RANGE_W < 4 || RANGE_W > 32) $error("RANGE_W out of range");
      if (LAMP_CYC == 0 || HOLD_CYC == 0 || IDLE_CYC == 0) $error("Counts must be nonzero");
      if (DEB_CYC == 21'h0) $error("DEB_CYC must be nonzero");
   end
   // Debounced buttons
   psmc_debounce #(.CNT_W(21), .STABLE_CYC(DEB_CYC)) u_deb_menu (
      .sys_clk(sys_clk), .reset_n(reset_n), .raw_in(btn_menu), .clean_out(menu_c));
   psmc_debounce #(.CNT_W(21), .STABLE_CYC(DEB_CYC)) u_deb_a (
      .sys_clk(sys_clk), .reset_n(reset_n), .raw_in(button_a), .clean_out(a_c));
   psmc_debounce #(.CNT_W(21), .STABLE_CYC(DEB_CYC)) u_deb_conf (
      .sys_clk(sys_clk), .reset_n(reset_n), .raw_in(btn_confirm), .clean_out(conf_c));
   assign chord = menu_c && a_c;
   assign any_btn = menu_c || a_c || conf_c;
   assign limit = (RANGE_W+7)'(range_span) * (RANGE_W+7)'(OFFSET_LIMIT_PCT);
   always_comb begin
      state_nxt = state_r;
      tmr_nxt = tmr_r + 38'h1;
      outen_nxt = outen_r;
      sw_nxt = sw_r;
      zadj_nxt = ZERO_ADJ_RESET;
      ofs_nxt = ofs_r;
      commit_nxt = 1'b0;
      aban_nxt = 1'b0;
      if (outen_r) begin
         sw_nxt = sw_request;
      end
      case (state_r)
         PSMC_LAMP: begin
            if (tmr_r >= 38'(LAMP_CYC - 1)) begin
               state_nxt = PSMC_DISP;
               tmr_nxt = '0;
               outen_nxt = 1'b1;
               sw_nxt = in_hyst_band ? 1'b0 : sw_request;
            end
         end
         PSMC_DISP: begin
            tmr_nxt = '0;
            if (menu_c && !a_c) begin
               state_nxt = PSMC_HOLD;
            end
         end
         PSMC_HOLD: begin
            if (!menu_c || a_c) begin
               state_nxt = PSMC_DISP;
               tmr_nxt = '0;
            end else if (tmr_r >= 38'(HOLD_CYC - 1)) begin
               tmr_nxt = '0;
               state_nxt = (access_code != CODE_NONE) ? PSMC_CODE : PSMC_PROG;
            end
         end
         PSMC_CODE: begin
            tmr_nxt = '0;
            if (code_entry_done) begin
               state_nxt = (code_entered == access_code) ? PSMC_PROG : PSMC_DISP;
            end
         end
         PSMC_PROG: begin
            tmr_nxt = '0;
            if (chord) begin
               state_nxt = PSMC_DISP;
            end else if (zero_select) begin
               zadj_nxt = 1'b1;
               if ({7'h0, offset_raw} * 7'd100 <= limit) begin
                  ofs_nxt = offset_raw;
               end
            end else if (edit_select) begin
               state_nxt = PSMC_EDIT;
            end
         end
         PSMC_EDIT: begin
            if (chord) begin
               state_nxt = PSMC_DISP;
               aban_nxt = 1'b1;
            end else if (any_btn) begin
               tmr_nxt = '0;
               if (conf_c) begin
                  state_nxt = PSMC_PROG;
                  commit_nxt = 1'b1;
               end
            end else if (tmr_r >= 38'(IDLE_CYC - 1)) begin
               state_nxt = PSMC_DISP;
               aban_nxt = 1'b1;
               tmr_nxt = '0;
            end
         end
         default: begin
            state_nxt = PSMC_LAMP;
            tmr_nxt = '0;
         end
      endcase
      if (state_r != PSMC_PROG) begin
         zadj_nxt = ZERO_ADJ_RESET;
      end
   end
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= PSMC_LAMP;
         tmr_r <= '0;
         outen_r <= 1'b0;
         sw_r <= 1'b0;
         zadj_r <= ZERO_ADJ_RESET;
         ofs_r <= '0;
         commit_r <= 1'b0;
         aban_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         tmr_r <= tmr_nxt;
         outen_r <= outen_nxt;
         sw_r <= sw_nxt;
         zadj_r <= zadj_nxt;
         ofs_r <= ofs_nxt;
         commit_r <= commit_nxt;
         aban_r <= aban_nxt;
      end
   end
   assign lamp_test = (state_r == PSMC_LAMP);
   assign outputs_enable = outen_r;
   assign switch_out = sw_r;
   assign prog_mode = (state_r == PSMC_PROG) || (state_r == PSMC_EDIT);
   assign code_prompt = (state_r == PSMC_CODE);
   assign edit_active = (state_r == PSMC_EDIT);
   assign edit_commit = commit_r;
   assign edit_abandon = aban_r;
   assign zero_offset_adjust = zadj_r;
   assign offset_valid = zadj_r;
   assign zero_offset = ofs_r;
   a_lamp_done: assert property (@(posedge sys_clk) disable iff (!reset_n)
      $fell(lamp_test) |-> outputs_enable) else $error("Lamp test end without outputs");
   a_start_inactive: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (lamp_test && in_hyst_band && state_nxt == PSMC_DISP) |=> !switch_out)
      else $error("Switch active at start in band");
   a_lamp_outputs_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
      lamp_test |-> !outputs_enable && !switch_out) else $error("Outputs on during lamp test");
   a_code_prompt: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (state_r == PSMC_HOLD && state_nxt == PSMC_PROG) |-> access_code == CODE_NONE)
      else $error("Prompt skipped with code set");
   a_code_fail: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (code_prompt && code_entry_done && code_entered != access_code) |=> state_r == PSMC_DISP)
      else $error("Wrong code not rejected");
   a_chord_exit: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (prog_mode && chord) |=> state_r == PSMC_DISP) else $error("Chord did not exit");
   a_idle_abandon: assert property (@(posedge sys_clk) disable iff (!reset_n)
      $rose(edit_abandon) |-> !edit_commit && state_r == PSMC_DISP) else $error("Bad abandon");
   a_offset_limit: assert property (@(posedge sys_clk) disable iff (!reset_n)
      $changed(zero_offset) |-> ({7'h0, zero_offset} * 7'd100 <= $past(limit)))
      else $error("Offset over limit");
   a_zero_prog_only: assert property (@(posedge sys_clk) disable iff (!reset_n)
      zero_offset_adjust |-> $past(state_r) == PSMC_PROG) else $error("Zero adjust outside prog");
   a_hold_entry: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (state_r == PSMC_HOLD && state_nxt != PSMC_HOLD && state_nxt != PSMC_DISP) |-> tmr_r >= 38'(HOLD_CYC - 1))
      else $error("Hold too short");
   a_hold_abort: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (state_r == PSMC_HOLD && !menu_c) |=> state_r == PSMC_DISP) else $error("Hold not aborted");
endmodule // psmc_top

// ==== src/psmc_pkg.sv ====
package psmc_pkg;
   localparam int unsigned CLK_HZ = 200_000_000;
   localparam int unsigned LAMP_TEST_MS = 1000;
   localparam int unsigned MENU_HOLD_MS = 5000;
   localparam int unsigned EDIT_TIMEOUT_MS = 60000;
   localparam int unsigned DEBOUNCE_US = 10000;
   localparam longint unsigned LAMP_TEST_CYC = longint'(CLK_HZ) / 1000 * LAMP_TEST_MS;
   localparam longint unsigned MENU_HOLD_CYC = longint'(CLK_HZ) / 1000 * MENU_HOLD_MS;
   localparam longint unsigned EDIT_TIMEOUT_CYC = longint'(CLK_HZ) / 1000 * EDIT_TIMEOUT_MS;
   localparam longint unsigned DEBOUNCE_CYC = longint'(CLK_HZ) / 1000000 * DEBOUNCE_US;
   localparam int unsigned CODE_W = 16;
   localparam logic [15:0] CODE_NONE = 16'h0000;
   localparam int unsigned OFFSET_LIMIT_PCT = 3;
   localparam logic ZERO_ADJ_RESET = 1'b0;
   typedef enum logic [2:0] {
      PSMC_LAMP = 3'b000,
      PSMC_DISP = 3'b001,
      PSMC_HOLD = 3'b011,
      PSMC_CODE = 3'b010,
      PSMC_PROG = 3'b110,
      PSMC_EDIT = 3'b111
   } psmc_state_t;
endpackage

// ==== src/psmc_debounce.sv ====
`timescale 1ns/10ps
module psmc_debounce #(
   parameter int unsigned CNT_W = 21,
   parameter logic [20:0] STABLE_CYC = 21'h1e8480
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic raw_in,
   output logic clean_out
);
   logic sync1_r, sync2_r, clean_r, clean_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   initial begin
      if (CNT_W != 21) $error("CNT_W must be 21");
   end
   always_comb begin
      clean_nxt = clean_r;
      cnt_nxt = '0;
      if (sync2_r != clean_r) begin
         cnt_nxt = cnt_r + 1'b1;
         if (cnt_r >= STABLE_CYC - 21'h1) begin
            clean_nxt = sync2_r;
            cnt_nxt = '0;
         end
      end
   end
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         clean_r <= 1'b0;
         cnt_r <= '0;
      end else begin
         sync1_r <= raw_in;
         sync2_r <= sync1_r;
         clean_r <= clean_nxt;
         cnt_r <= cnt_nxt;
      end
   end
   assign clean_out = clean_r;
endmodule // psmc_debounce

// ==== test/psmc_operator.sv ====
`timescale 1ns/10ps
module psmc_operator (
   input wire logic sys_clk,
   input wire logic [2:0] press,
   output logic [2:0] btn
);
   logic [2:0] last = 3'h0;
   int left[3] = '{0, 0, 0};
   // Contacts chatter for a few cycles on every change before settling
   always @(posedge sys_clk) begin
      for (int i = 0; i < 3; i++) begin
         if (press[i] != last[i]) left[i] = 3;
         if (left[i] != 0) begin
            btn[i] <= ~btn[i];
            left[i]--;
         end else btn[i] <= press[i];
      end
      last <= press;
   end
endmodule // psmc_operator

// ==== test/tb_top.sv ====
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
   $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
`define WAITC(c) begin n = 0; while (!(c) && n < 200) begin tick(); n++; end end
module tb_top;
   import psmc_pkg::*;
   logic sys_clk = 1'b0, reset_n = 1'b0, code_entry_done = 1'b0, edit_select = 1'b0, zero_select = 1'b0;
   logic in_hyst_band = 1'b1, sw_request = 1'b1;
   logic [2:0] press = 3'h0, btn;
   logic [15:0] access_code = 16'h1234, code_entered = 16'h0000, offset_raw = 16'h0003, range_span = 16'h0064;
   logic lamp_test, outputs_enable, switch_out, prog_mode, code_prompt, edit_active;
   logic zero_offset_adjust, edit_abandon, edit_commit, offset_valid;
   logic [15:0] zero_offset;
   int n_fail = 0, compares = 0, n;
   logic pr;
   psmc_operator op_i (.sys_clk(sys_clk), .press(press), .btn(btn));
   psmc_top #(.LAMP_CYC(20), .HOLD_CYC(30), .IDLE_CYC(40), .DEB_CYC(21'h000004), .RANGE_W(16)) dut (
      .sys_clk(sys_clk), .reset_n(reset_n), .btn_menu(btn[0]), .button_a(btn[1]), .btn_confirm(btn[2]),
      .access_code(access_code), .code_entry_done(code_entry_done), .code_entered(code_entered),
      .edit_select(edit_select), .zero_select(zero_select), .in_hyst_band(in_hyst_band),
      .sw_request(sw_request), .offset_raw(offset_raw), .range_span(range_span), .lamp_test(lamp_test),
      .outputs_enable(outputs_enable), .switch_out(switch_out), .prog_mode(prog_mode),
      .code_prompt(code_prompt), .edit_active(edit_active), .edit_commit(edit_commit),
      .edit_abandon(edit_abandon), .zero_offset_adjust(zero_offset_adjust), .offset_valid(offset_valid),
      .zero_offset(zero_offset));
   initial begin
      forever #2.5 sys_clk = ~sys_clk;
   end
   task tick();
      @(posedge sys_clk);
      #1;
   endtask
   task op(input logic [2:0] p);
      @(posedge sys_clk) press <= p;
      #1;
   endtask
   task go_prog(input logic [15:0] code);
      op(3'h1);
      `WAITC(code_prompt === 1'b1 || prog_mode === 1'b1)
      `CHK((n >= 30 && n < 80), 1'b1)
      pr = code_prompt;
      op(3'h0);
      if (pr) begin
         @(posedge sys_clk) code_entered <= code;
         code_entry_done <= 1'b1;
         @(posedge sys_clk) code_entry_done <= 1'b0;
      end
      repeat (12) tick();
   endtask
   task s_lamp();
      repeat (20) tick();
      `CHK(lamp_test, 1'b1)
      @(posedge sys_clk) reset_n <= 1'b1;
      `WAITC(lamp_test !== 1'b1)
      `CHK((n >= 19 && n <= 21), 1'b1)
      `CHK(outputs_enable, 1'b1)
      `CHK(switch_out, 1'b0)
      `CHK(zero_offset_adjust, 1'b0)
   endtask
   task s_code();
      go_prog(16'h4321);
      `CHK(pr, 1'b1)
      `CHK(prog_mode, 1'b0)
      go_prog(16'h1234);
      `CHK(prog_mode, 1'b1)
   endtask
   task s_chord();
      op(3'h3);
      repeat (15) tick();
      `CHK(prog_mode, 1'b0)
      op(3'h0);
      repeat (15) tick();
   endtask
   task s_edit();
      @(posedge sys_clk) edit_select <= 1'b1;
      @(posedge sys_clk) edit_select <= 1'b0;
      #1;
      `CHK(edit_active, 1'b1)
      `WAITC(edit_abandon === 1'b1)
      `CHK((n >= 37 && n <= 42), 1'b1)
      `CHK(edit_commit, 1'b0)
      tick();
      `CHK(prog_mode, 1'b0)
   endtask
   task zero(input logic [15:0] off, input logic [15:0] exp);
      @(posedge sys_clk) offset_raw <= off;
      zero_select <= 1'b1;
      @(posedge sys_clk) zero_select <= 1'b0;
      #1;
      `CHK(zero_offset_adjust, 1'b1)
      `CHK(offset_valid, 1'b1)
      `CHK(zero_offset, exp)
      tick();
      `CHK(zero_offset_adjust, 1'b0)
      `CHK(zero_offset, exp)
   endtask
   task s_commit();
      @(posedge sys_clk) edit_select <= 1'b1;
      @(posedge sys_clk) edit_select <= 1'b0;
      op(3'h4);
      `WAITC(edit_commit === 1'b1)
      `CHK((n < 30), 1'b1)
      `CHK((prog_mode === 1'b1 && edit_active === 1'b0), 1'b1)
      op(3'h0);
      repeat (15) tick();
   endtask
   task results();
      $display("Checks %0d, mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      s_lamp();
      s_code();
      s_chord();
      @(posedge sys_clk) access_code <= 16'h0000;
      go_prog(16'h0000);
      `CHK(pr, 1'b0)
      `CHK(prog_mode, 1'b1)
      zero(16'h0003, 16'h0003);
      zero(16'h0004, 16'h0003);
      s_commit();
      s_edit();
      results();
   end
   initial begin
      #50us;
      n_fail++;
      results();
   end
endmodule // tb_top
